//--- hw/mbl_regs.svh
`ifndef MBL_REGS_SVH
`define MBL_REGS_SVH
// timing of the line code at the 40 MHz core clock
`define MBL_CLK_NS 25
`define MBL_HALF_BIT_NS 100
`define MBL_HALF_BIT_CYC (`MBL_HALF_BIT_NS / `MBL_CLK_NS)
`define MBL_BIT_CYC (2 * `MBL_HALF_BIT_CYC)
// longest legal run of one level, in half-bits
`define MBL_MAX_RUN_HALVES 2
// packet framing defaults
`define MBL_PREAMBLE_BITS 8
`define MBL_SYNC_BITS 16
`define MBL_SYNC_WORD 16'hF35A
`define MBL_CRC_BITS 16
`define MBL_CRC_POLY 16'h1021
`define MBL_CRC_INIT 16'hFFFF
// low-rate tone keying: divide the 9.537 MHz reference by 2 or 4
`define MBL_HIGH_TONE_DIV 2
`define MBL_LOW_TONE_DIV 4
`endif

//--- hw/mbl_pkg.sv
package mbl_pkg;
  // transmit framing phases
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_BODY, TX_CRC} mbl_tx_state_t;
  // receive phases
  typedef enum logic [1:0] {RX_HUNT, RX_BODY} mbl_rx_state_t;
endpackage

//--- hw/mbl_tone_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "mbl_regs.svh"
// tone keyer for the low-rate variant, clocked by the core clock; the
// reference is sampled so the tone toggles on reference edges
module mbl_tone_gen
  import mbl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_synth_reference,
  input wire logic i_bit,
  output logic o_tone
);
  import mbl_pkg::*;
  typedef struct packed {
    logic [1:0] sync;   // two-flop synchroniser of the reference
    logic ref_d;        // last synchronised level, for edge detect
    logic [2:0] cnt;    // reference half-cycles counted
    logic tone;         // tone output level
  } mbl_tone_st_t;
  mbl_tone_st_t st_reg;
  mbl_tone_st_t st_next;
  logic [2:0] div;

  // next state: toggle after div reference edges (both edges counted)
  always_comb
  begin
    st_next = st_reg;
    div = i_bit ? 3'(`MBL_HIGH_TONE_DIV) : 3'(`MBL_LOW_TONE_DIV);  // [R14]
    st_next.sync = {st_reg.sync[0], i_synth_reference};
    st_next.ref_d = st_reg.sync[1];
    if (st_reg.sync[1] != st_reg.ref_d)
    begin
      if (st_reg.cnt + 3'h1 >= div)
      begin
        st_next.cnt = 3'h0;
        st_next.tone = ~st_reg.tone;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + 3'h1;
      end
    end
  end

  // state register
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_tone = st_reg.tone;
endmodule
`default_nettype wire

//--- hw/mbl_link.sv
// Operation
// [R1] baseband codes at nominal 5 Mbps
// [R2] transmit pulses last 100 to 200 ns
// [R3] baseband implements encoder and decoder
// [R4] one is high-low, zero low-high
// [R5] 200 ns bit, two 100 ns halves
// [R6] runs over two halves are invalid
// [R7] transmit line may hold any level
// [R8] keep half-bit timing exact
// [R9] receive path tuned for 4-6 Mbps
// [R10] preamble, sync, header, payload, check
// [R11] check field is a CRC
// [R12] guard interval between packets
// [R13] five control lines as outputs
// [R14] low-rate tones from divided reference
// [R15] high tone reads high, low reads low
// [R16] tone keying only up to 100 kb/s
// [R17] sample receive at eight times bitrate
// [R18] decide bits from second half only
// [R19] flag bits lacking mid-bit transition
`timescale 1ns/100ps
`default_nettype none
`include "mbl_regs.svh"
module mbl_link
  import mbl_pkg::*;
#(
  parameter int HDR_BITS = 8,
  parameter int GUARD_CYC = 40,
  parameter logic [15:0] SYNC_WORD = `MBL_SYNC_WORD
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_low_rate,
  input wire logic i_tx_start,
  input wire logic [15:0] i_tx_len,
  output logic o_tx_ready,
  input wire logic i_tx_bit,
  output logic o_tx_bit_take,
  output logic o_tx_busy,
  output logic o_tx_data,
  input wire logic i_rx_data,
  input wire logic i_synth_reference,
  input wire logic i_lr_tx_bit,
  output logic o_lr_rx_bit,
  output logic o_rx_sync,
  output logic o_rx_bit,
  output logic o_rx_bit_valid,
  output logic o_rx_code_err,
  output logic o_rx_crc,
  output logic [15:0] o_rx_crc_val,
  input wire logic [4:0] i_ctrl,
  output logic [4:0] o_ctrl
);
  import mbl_pkg::*;

  localparam int HALF = `MBL_HALF_BIT_CYC;
  localparam int BITC = `MBL_BIT_CYC;

  typedef struct packed {
    mbl_tx_state_t txs;   // transmit phase
    logic [2:0] ph;       // cycle within a bit
    logic [15:0] bcnt;    // bits left in the phase
    logic [15:0] sh;      // sync shift register
    logic [15:0] txcrc;   // running transmit crc
    logic cur;            // data bit being sent
    logic line;           // transmit line level
    logic [7:0] guard;    // guard cycles remaining
    logic [1:0] rsync;    // receive pin synchroniser
    logic rprev;          // last sampled receive level
    logic [2:0] rph;      // cycle within received bit
    logic [3:0] run;      // samples since last edge; wide enough to pass a two-half run
    logic mid_seen;       // bit-centre edge found in this bit
    logic [15:0] corr;    // sync correlation register
    mbl_rx_state_t rxs;   // receive phase
    logic [15:0] rxcrc;   // running receive crc
    logic rbit;           // decided bit
    logic rvalid;         // decided bit strobe
    logic rerr;           // coding error strobe
    logic rsyncf;         // sync found strobe
    logic [4:0] ctrl;     // control line levels
    logic [1:0] lrs;      // low-rate receive synchroniser
  } mbl_st_t;
  mbl_st_t st_reg;
  mbl_st_t st_next;
  logic tone;

  // crc step shared by both directions
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[15] ^ b;
    crc_step = {c[14:0], 1'b0} ^ (fb ? `MBL_CRC_POLY : 16'h0000);
  endfunction

  // manchester level for a bit at a phase within the bit
  function automatic logic mch(input logic b, input logic [2:0] p);
    mch = (p < 3'(HALF)) ? b : ~b;  // [R4] [R5]
  endfunction

  mbl_tone_gen u_tone (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_synth_reference(i_synth_reference),
    .i_bit(i_lr_tx_bit),
    .o_tone(tone)
  );

  // next-state logic for framer, encoder and decoder
  always_comb
  begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.rerr = 1'b0;
    st_next.rsyncf = 1'b0;
    st_next.ctrl = i_ctrl;  // [R13]
    // transmit: bit timer runs in every non-idle phase
    if (st_reg.txs == TX_IDLE)
    begin
      // line rests low; a held level is fine on the dc-coupled pin
      st_next.line = 1'b0;  // [R7]
      if (st_reg.guard != 8'h00)
        st_next.guard = st_reg.guard - 8'h01;  // [R12]
      else if (i_tx_start)
      begin
        st_next.txs = TX_PRE;  // [R10]
        st_next.bcnt = 16'(`MBL_PREAMBLE_BITS - 1);
        st_next.ph = 3'h0;
        st_next.cur = 1'b1;
        st_next.sh = SYNC_WORD;
        st_next.txcrc = `MBL_CRC_INIT;
      end
    end
    else
    begin
      // exact 4-cycle halves keep duty cycle tight
      st_next.line = mch(st_reg.cur, st_reg.ph);  // [R2] [R8] [R1]
      st_next.ph = st_reg.ph + 3'h1;
      if (st_reg.ph == 3'(BITC - 1))
      begin
        st_next.ph = 3'h0;
        if (st_reg.txs == TX_BODY)
          st_next.txcrc = crc_step(st_reg.txcrc, st_reg.cur);  // [R11]
        if (st_reg.txs == TX_CRC)
          st_next.txcrc = {st_reg.txcrc[14:0], 1'b0};
        st_next.bcnt = st_reg.bcnt - 16'h1;
        if (st_reg.bcnt == 16'h0)
        begin
          case (st_reg.txs)
            TX_PRE:
            begin
              st_next.txs = TX_SYNC;
              st_next.bcnt = 16'(`MBL_SYNC_BITS - 1);
            end
            TX_SYNC:
            begin
              st_next.txs = TX_BODY;
              st_next.bcnt = 16'(HDR_BITS) + i_tx_len - 16'h1;
            end
            TX_BODY:
            begin
              st_next.txs = TX_CRC;
              st_next.bcnt = 16'(`MBL_CRC_BITS - 1);
            end
            default:
            begin
              st_next.txs = TX_IDLE;
              st_next.guard = 8'(GUARD_CYC);
            end
          endcase
        end
        // pick next data bit
        case (st_next.txs)
          TX_PRE: st_next.cur = ~st_reg.cur;
          TX_SYNC:
          begin
            st_next.cur = st_next.sh[15];
            st_next.sh = {st_reg.sh[14:0], 1'b0};
            if (st_reg.txs == TX_SYNC)
            begin
              // sh already moved past the bit on the line, so its top bit is next
              st_next.cur = st_reg.sh[15];
              st_next.sh = {st_reg.sh[14:0], 1'b0};
            end
          end
          TX_BODY: st_next.cur = i_tx_bit;
          TX_CRC: st_next.cur = (st_reg.txs == TX_CRC) ? st_reg.txcrc[14] : st_next.txcrc[15];
          default: st_next.cur = 1'b0;
        endcase
      end
    end
    // receive: 8 samples per bit at the core rate  [R17] [R9]
    st_next.rsync = {st_reg.rsync[0], i_rx_data};
    st_next.lrs = {st_reg.lrs[0], i_rx_data};  // [R15]
    st_next.rprev = st_reg.rsync[1];
    st_next.rph = st_reg.rph + 3'h1;
    st_next.run = (st_reg.run == 4'hF) ? st_reg.run : st_reg.run + 4'h1;
    if (st_reg.rsync[1] != st_reg.rprev)
    begin
      st_next.run = 4'h0;
      // edge near the middle marks the bit centre; realign to it
      if (st_reg.rph >= 3'(HALF - 1) || st_reg.run > 4'(HALF))
      begin
        st_next.rph = 3'(HALF + 1);
        st_next.mid_seen = 1'b1;
      end
    end
    // correlate sync once per bit, on its last sample, in the hunt phase  [R18]
    if (st_reg.rph == 3'(BITC - 1))
    begin
      st_next.rph = 3'h0;
      st_next.mid_seen = 1'b0;
      st_next.rbit = ~st_reg.rsync[1];  // [R3] [R18]
      st_next.rvalid = (st_reg.rxs == RX_BODY);
      // long run or missing transition is a coding error  [R6]
      st_next.rerr = (st_reg.rxs == RX_BODY)
        && (!st_reg.mid_seen || st_reg.run > 4'(`MBL_MAX_RUN_HALVES * HALF));  // [R19]
      st_next.corr = {st_reg.corr[14:0], ~st_reg.rsync[1]};
      if (st_reg.rxs == RX_HUNT && {st_reg.corr[14:0], ~st_reg.rsync[1]} == SYNC_WORD)
      begin
        st_next.rxs = RX_BODY;
        st_next.rsyncf = 1'b1;
        st_next.rxcrc = `MBL_CRC_INIT;
      end
      if (st_reg.rxs == RX_BODY)
        st_next.rxcrc = crc_step(st_reg.rxcrc, ~st_reg.rsync[1]);  // [R11]
    end
    if (i_tx_start && st_reg.txs == TX_IDLE)
      st_next.rxs = RX_HUNT;
  end

  // state register
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // outputs; low-rate mode keys tones instead  [R16]
  assign o_tx_data = i_low_rate ? tone : st_reg.line;
  assign o_tx_ready = (st_reg.txs == TX_IDLE) && (st_reg.guard == 8'h00);
  assign o_tx_busy = (st_reg.txs != TX_IDLE);
  assign o_tx_bit_take = (st_reg.txs == TX_BODY) && (st_reg.ph == 3'(BITC - 1)) && (st_reg.bcnt != 16'h0);
  assign o_lr_rx_bit = st_reg.lrs[1];
  assign o_rx_sync = st_reg.rsyncf;
  assign o_rx_bit = st_reg.rbit;
  assign o_rx_bit_valid = st_reg.rvalid;
  assign o_rx_code_err = st_reg.rerr;
  assign o_rx_crc = (st_reg.rxcrc == 16'h0000);
  assign o_rx_crc_val = st_reg.rxcrc;
  assign o_ctrl = st_reg.ctrl;
endmodule
`default_nettype wire

//--- dv/mbl_xcvr_model.sv
`timescale 1ns/100ps
`default_nettype none
// transceiver stand-in: passes the coded line back and makes the reference
module mbl_xcvr_model
(
  input wire logic i_tx_data,
  input wire logic i_low_rate,
  input wire logic i_hold,
  output logic o_rx_data,
  output logic o_ref
);
  realtime last_edge = 0.0; // time of the previous line edge
  logic tone_hi = 1'b0; // detector level for the keyed tones
  // reference near 9.5 MHz, free of any phase tie to the core clock
  initial
  begin
    o_ref = 1'b0;
    forever #52.4 o_ref = ~o_ref;
  end
  // short tone half-periods read high, long ones low
  always @(i_tx_data)
  begin
    tone_hi = ($realtime - last_edge) < 150.0;
    last_edge = $realtime;
  end
  // no coding in the device: outside low-rate mode the line is returned as sent; hold freezes it
  always @*
  begin
    if (i_low_rate)
      o_rx_data = tone_hi;
    else if (!i_hold)
      o_rx_data = i_tx_data;
  end
endmodule
`default_nettype wire

//--- dv/mbl_link_sva.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the link
module mbl_link_sva
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_low_rate,
  input wire logic i_tx_start,
  input wire logic o_tx_ready,
  input wire logic o_tx_bit_take,
  input wire logic o_tx_busy,
  input wire logic o_tx_data,
  input wire logic o_rx_bit_valid,
  input wire logic o_rx_code_err,
  input wire logic [4:0] i_ctrl,
  input wire logic [4:0] o_ctrl
);
  logic [3:0] run_reg; // cycles spent at the present line level
  logic last_reg; // line level one cycle ago
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // run restarts on a level change and outside packets
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      run_reg <= 4'h0;
      last_reg <= 1'b0;
    end
    else
    begin
      run_reg <= (o_tx_busy && o_tx_data == last_reg) ? run_reg + 4'h1 : 4'h1;
      last_reg <= o_tx_data;
    end
  end
  property p_start; i_tx_start && o_tx_ready |=> o_tx_busy; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_first; $rose(o_tx_busy) && !i_low_rate |=> o_tx_data [*4] ##1 !o_tx_data [*4]; endproperty
  a_first: assert property (p_first) else $error("packet does not open high then low");
  property p_half; o_tx_busy && !i_low_rate && $changed(o_tx_data) |=> $stable(o_tx_data) [*3]; endproperty
  a_half: assert property (p_half) else $error("half-bit shorter than four cycles");
  property p_run; o_tx_busy && !i_low_rate |-> run_reg <= 4'h8; endproperty
  a_run: assert property (p_run) else $error("line level held over two half-bits");
  property p_ready; o_tx_busy |-> !o_tx_ready; endproperty
  a_ready: assert property (p_ready) else $error("ready while busy");
  property p_guard; $fell(o_tx_busy) |-> !o_tx_ready [*8]; endproperty
  a_guard: assert property (p_guard) else $error("no guard gap after packet");
  property p_take; o_tx_bit_take |-> o_tx_busy; endproperty
  a_take: assert property (p_take) else $error("bit taken outside packet");
  property p_ctrl; $past(i_rst_n) |-> o_ctrl == $past(i_ctrl); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control lines not passed");
  property p_err; o_rx_code_err |-> o_rx_bit_valid; endproperty
  a_err: assert property (p_err) else $error("coding error without bit strobe");
  c_take: cover property (o_tx_bit_take);
  c_err: cover property (o_rx_code_err);
  c_guard: cover property ($fell(o_tx_busy));
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "mbl_regs.svh"
module testbench;
  import mbl_pkg::*;
  localparam int GUARD = 40; // guard gap handed to the link
  localparam logic [63:0] PAT = 64'hC3A50F965A3CE117; // body bits, msb first
  logic i_core_clk, i_rst_n, i_low_rate, i_tx_start, i_tx_bit, i_rx_data, i_synth_reference, i_lr_tx_bit;
  logic o_tx_ready, o_tx_bit_take, o_tx_busy, o_tx_data, o_lr_rx_bit, o_rx_sync, o_rx_bit;
  logic o_rx_bit_valid, o_rx_code_err, o_rx_crc, hold_rx;
  logic [15:0] i_tx_len, o_rx_crc_val;
  logic [4:0] i_ctrl, o_ctrl;
  logic [63:0] rxq; // bits decoded after the last sync hit
  int idx, rxn, errs, n_mismatch, samples_checked;
  mbl_link #(.HDR_BITS(8), .GUARD_CYC(GUARD)) i_dut (.i_core_clk, .i_rst_n, .i_low_rate, .i_tx_start,
    .i_tx_len, .o_tx_ready, .i_tx_bit, .o_tx_bit_take, .o_tx_busy, .o_tx_data, .i_rx_data,
    .i_synth_reference, .i_lr_tx_bit, .o_lr_rx_bit, .o_rx_sync, .o_rx_bit, .o_rx_bit_valid,
    .o_rx_code_err, .o_rx_crc, .o_rx_crc_val, .i_ctrl, .o_ctrl);
  mbl_xcvr_model i_xcvr (.i_tx_data(o_tx_data), .i_low_rate(i_low_rate), .i_hold(hold_rx),
    .o_rx_data(i_rx_data), .o_ref(i_synth_reference));
  initial
  begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // next body bit is offered ahead; a take pulse moves on
  always @(negedge i_core_clk) i_tx_bit <= PAT[63 - idx];
  always @(posedge i_core_clk) if (o_tx_bit_take === 1'b1) idx <= idx + 1;
  // collect decoded bits and count coding errors
  always @(posedge i_core_clk)
  begin
    if (o_rx_sync === 1'b1)
      rxn <= 0;
    else if (o_rx_bit_valid === 1'b1 && rxn < 64)
    begin
      rxq[63 - rxn] <= o_rx_bit;
      rxn <= rxn + 1;
    end
    if (o_rx_code_err === 1'b1)
      errs <= errs + 1;
  end
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (exp !== got)
    begin
      n_mismatch++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one packet, read off the line half by half; glitch freezes the return path in one bit
  task automatic send_pkt(input logic glitch);
    logic [63:0] seen;
    logic h1;
    seen = 64'h0;
    rxq = 64'h0;
    idx = 0;
    errs = 0;
    i_tx_start = 1'b1;
    @(negedge i_core_clk);
    i_tx_start = 1'b0;
    chk(16'h1, {15'h0, o_tx_busy});
    for (int b = 0; b < 56; b++)
    begin
      @(negedge i_core_clk);
      i_tx_start = (b == 10);
      // the first body bit leaves at the sync turn with no take pulse
      if (b == 24)
        idx = 1;
      hold_rx = glitch && (b == 30);
      h1 = o_tx_data;
      repeat (4) @(negedge i_core_clk);
      chk({15'h0, ~h1}, {15'h0, o_tx_data});
      seen = {seen[62:0], h1};
      repeat (3) @(negedge i_core_clk);
    end
    chk(16'h00AA, {8'h0, seen[55:48]});
    chk(`MBL_SYNC_WORD, seen[47:32]);
    chk(PAT[63:48], seen[31:16]);
    repeat (2) @(negedge i_core_clk);
    chk(16'h0, {15'h0, o_tx_busy});
    i_tx_start = 1'b1;
    @(negedge i_core_clk);
    i_tx_start = 1'b0;
    chk(16'h0, {15'h0, o_tx_busy});
    repeat (GUARD) @(negedge i_core_clk);
    chk(16'h1, {15'h0, o_tx_ready});
    chk({15'h0, ~glitch}, {15'h0, o_rx_crc});
    chk({15'h0, glitch}, {15'h0, errs != 0});
    chk(16'h0010, idx[15:0]);
    if (!glitch)
    begin
      chk(PAT[63:48], rxq[63:48]);
      chk(16'h0000, o_rx_crc_val);
    end
  endtask
  initial
  begin
    {i_rst_n, i_low_rate, i_tx_start, i_tx_bit, i_lr_tx_bit, hold_rx} = 6'h0;
    i_tx_len = 16'h8;
    i_ctrl = 5'h0;
    {idx, rxn, errs, n_mismatch, samples_checked} = '0;
    repeat (10) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    chk(16'h1, {15'h0, o_tx_ready});
    for (int k = 0; k < 6; k++)
    begin
      i_ctrl = 5'h1 << k;
      @(negedge i_core_clk);
      chk({11'h0, 5'h1 << k}, {11'h0, o_ctrl});
    end
    send_pkt(1'b0);
    send_pkt(1'b1);
    send_pkt(1'b0);
    i_low_rate = 1'b1;
    for (int v = 1; v >= 0; v--)
    begin
      i_lr_tx_bit = v[0];
      repeat (40) @(negedge i_core_clk);
      chk({15'h0, v[0]}, {15'h0, o_lr_rx_bit});
    end
    print_verdict();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
bind mbl_link mbl_link_sva i_sva (.i_core_clk, .i_rst_n, .i_low_rate, .i_tx_start, .o_tx_ready,
  .o_tx_bit_take, .o_tx_busy, .o_tx_data, .o_rx_bit_valid, .o_rx_code_err, .i_ctrl, .o_ctrl);
`default_nettype wire
